// >>> glue_logic_pkg.sv
// Purpose: constants and types for the programmable glue logic block
// Assumes: 200 MHz bus clock, Avalon-MM register slave, 32-bit words
// Notes: register offsets are byte addresses, one register per word
// Behaviour
// [RULE1] output is truth bit indexed by inputs
// [RULE2] two tables, three inputs, masked means low
// [RULE3] inputs 0,1 from second, 2 from third
// [RULE4] feedback source gives sequential output
// [RULE5] linked source gives table 1 to table 0
// [RULE6] two event lines selectable on every input
// [RULE7] pin source follows table's own pin
// [RULE8] filter delays output two to five cycles
// [RULE9] filter cleared one cycle after disable
// [RULE10] edge detector pulses on rising edge
// [RULE11] software pairs edge detect with filter
// [RULE12] edge state cleared one cycle after disable
// [RULE13] sequential element has four selectable functions
// [RULE14] sequential inputs from the two table outputs
// [RULE15] sequential element clocked like its table
// [RULE16] table 0 disabled clears sequential element
// [RULE17] sequential select writable only table 0 off
// [RULE18] table control writable only while disabled
// [RULE19] enabling write may update protected bits
// [RULE20] global enable and per table enables
// [RULE21] keeps running during processor debug halt
// [RULE22] output combinational or through filter
// [RULE23] sequential select codes zero to four
// [RULE24] jk: hold, clear, set, toggle
// [RULE25] rs: hold, clear, set, both forbidden
// [RULE26] clock source: bus clock or input 2
// [RULE27] d flip-flop loads d when gate high
// [RULE28] d latch follows d while gate high
package glue_logic_pkg;
    // byte offsets of the registers
    localparam logic [5:0] OFS_GLOBAL = 6'h00;
    localparam logic [5:0] OFS_SEQ = 6'h04;
    localparam logic [5:0] OFS_T0_A = 6'h14;
    localparam logic [5:0] OFS_T0_B = 6'h18;
    localparam logic [5:0] OFS_T0_C = 6'h1c;
    localparam logic [5:0] OFS_T0_TRUTH = 6'h20;
    localparam logic [5:0] OFS_TABLE_STRIDE = 6'h10;
    localparam logic [5:0] OFS_STATUS = 6'h34;
    // bit positions in table control first and in global control
    localparam int BIT_ENABLE = 0;
    localparam int BIT_OUTEN = 3;
    localparam int BIT_FILT_LO = 4;
    localparam int BIT_TABLE_CLOCK_SOURCE = 6;
    localparam int BIT_EDGE = 7;
    localparam int BIT_GLOBAL_EN = 0;
    // reset values
    localparam logic [7:0] RST_CTRL = 8'h00;
    localparam logic [3:0] RST_SEQ = 4'h0;
    // input source codes
    localparam logic [3:0] SRC_MASK = 4'h0;
    localparam logic [3:0] SRC_FEEDBACK = 4'h1;
    localparam logic [3:0] SRC_LINK = 4'h2;
    localparam logic [3:0] SRC_EVENT_LINE_ZERO = 4'h3;
    localparam logic [3:0] SRC_EVENT_LINE_ONE = 4'h4;
    localparam logic [3:0] SRC_PIN = 4'h5;
    localparam logic [3:0] SRC_PERIPH0 = 4'h6;
    localparam logic [3:0] SRC_PERIPH1 = 4'h7;
    // filter settings
    localparam logic [1:0] FILT_NONE = 2'h0;
    localparam logic [1:0] FILT_SYNC = 2'h1;
    localparam logic [1:0] FILT_FILTER = 2'h2;
    // sequential function codes
    localparam logic [3:0] SEQ_DISABLE = 4'h0;
    localparam logic [3:0] SEQ_DFF = 4'h1;
    localparam logic [3:0] SEQ_JK = 4'h2;
    localparam logic [3:0] SEQ_LATCH = 4'h3;
    localparam logic [3:0] SEQ_RS = 4'h4;
    // per table external inputs
    typedef struct packed {
        logic [2:0] pins;
        logic [1:0] periph;
    } table_in_type;
    // control fields of one table
    typedef struct packed {
        logic [7:0] ctrl_a;
        logic [7:0] ctrl_b;
        logic [3:0] ctrl_c;
        logic [7:0] truth;
    } table_cfg_type;
endpackage

// >>> glue_logic.sv
// Purpose: pair of three-input lookup tables with filter, edge detector
//          and one shared sequential element, behind an Avalon-MM slave
// Assumes: all inputs synchronous to i_clk; input 2 clocking is done
//          as a sampled enable on i_clk, not a second clock domain
// Notes: outputs are registered, so every path adds one i_clk cycle
`timescale 1ns/1ps
module glue_logic (
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire logic [5:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    input wire logic [3:0] i_avs_byteenable,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    input wire logic [2:0] i_table0_input_pins,
    input wire logic [2:0] i_table1_input_pins,
    input wire logic i_event_line_zero,
    input wire logic i_event_line_one,
    input wire logic [1:0] i_periph,
    input wire logic i_debug_halt,
    output logic [1:0] o_table_output_pin,
    output logic [1:0] o_table_event,
    output logic o_sequential_output
);
    // reset synchroniser, release through two flops
    logic rst_meta_r;
    logic rst_sync_r;
    logic nrst;
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            rst_meta_r <= 1'b0;
            rst_sync_r <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_sync_r <= rst_meta_r;
        end
    end
    assign nrst = rst_sync_r;

    // truth lookup used by both tables
    function automatic logic lut_eval(input logic [7:0] t,
                                      input logic [2:0] idx);
        // [RULE1] index with input 2 as msb
        lut_eval = t[idx];
    endfunction

    // source mux for all six inputs
    function automatic logic src_mux(input logic [3:0] sel,
                                     input logic seq,
                                     input logic link,
                                     input logic ev0,
                                     input logic ev1,
                                     input logic pin,
                                     input logic [1:0] per);
        unique case (sel)
            // [RULE4] feedback from sequential element
            glue_logic_pkg::SRC_FEEDBACK: src_mux = seq;
            // [RULE5] linked neighbour table
            glue_logic_pkg::SRC_LINK: src_mux = link;
            // [RULE6] event line sources
            glue_logic_pkg::SRC_EVENT_LINE_ZERO: src_mux = ev0;
            glue_logic_pkg::SRC_EVENT_LINE_ONE: src_mux = ev1;
            // [RULE7] dedicated pin level
            glue_logic_pkg::SRC_PIN: src_mux = pin;
            glue_logic_pkg::SRC_PERIPH0: src_mux = per[0];
            glue_logic_pkg::SRC_PERIPH1: src_mux = per[1];
            // [RULE2] masked and unused codes read low
            default: src_mux = 1'b0;
        endcase
    endfunction

    // control registers
    logic global_en_r;
    logic [3:0] seq_sel_r;
    logic [7:0] ctrl_a_r [2];
    logic [7:0] ctrl_b_r [2];
    logic [3:0] ctrl_c_r [2];
    logic [7:0] truth_r [2];
    logic seq_r; // sequential element state
    logic wait_r; // one wait cycle per access

    // bus decode: table index from address
    logic acc;
    logic wr_go;
    logic in_tbl;
    logic [5:0] rel;
    logic tsel;
    logic [5:0] tofs;
    assign acc = i_avs_read | i_avs_write;
    // access taken while waitrequest is low
    assign wr_go = i_avs_write & ~wait_r;
    assign in_tbl = (i_avs_address >= glue_logic_pkg::OFS_T0_A) &&
                    (i_avs_address < glue_logic_pkg::OFS_STATUS) &&
                    (i_avs_address[1:0] == 2'b00);
    assign rel = i_avs_address - glue_logic_pkg::OFS_T0_A;
    assign tsel = rel[4];
    assign tofs = {2'b00, rel[3:0]} + glue_logic_pkg::OFS_T0_A;

    // one wait cycle, then the answer
    always_ff @(posedge i_clk or negedge nrst) begin
        if (!nrst) begin
            wait_r <= 1'b1;
        end else if (acc && wait_r) begin
            wait_r <= 1'b0;
        end else begin
            wait_r <= 1'b1;
        end
    end
    assign o_avs_waitrequest = wait_r;

    // global control register
    always_ff @(posedge i_clk or negedge nrst) begin
        if (!nrst) begin
            global_en_r <= 1'b0;
        end else if (wr_go && i_avs_byteenable[0] &&
                     i_avs_address == glue_logic_pkg::OFS_GLOBAL) begin
            // [RULE20] whole block switch
            global_en_r <= i_avs_writedata[glue_logic_pkg::BIT_GLOBAL_EN];
        end
    end

    // sequential select, protected by table 0 enable
    always_ff @(posedge i_clk or negedge nrst) begin
        if (!nrst) begin
            seq_sel_r <= glue_logic_pkg::RST_SEQ;
        end else if (wr_go && i_avs_byteenable[0] &&
                     i_avs_address == glue_logic_pkg::OFS_SEQ &&
                     !ctrl_a_r[0][glue_logic_pkg::BIT_ENABLE]) begin
            // [RULE17] only while table 0 is off
            seq_sel_r <= i_avs_writedata[3:0];
        end
    end

    // per table control registers
    for (genvar n = 0; n < 2; n++) begin : g_regs
        logic hit;
        logic prot_ok;
        logic new_en;
        assign hit = wr_go && i_avs_byteenable[0] && in_tbl && (tsel == n);
        assign new_en = i_avs_writedata[glue_logic_pkg::BIT_ENABLE];
        // [RULE18] [RULE19] open while off or when this write enables
        assign prot_ok = !ctrl_a_r[n][glue_logic_pkg::BIT_ENABLE] ||
                         (tofs == glue_logic_pkg::OFS_T0_A && new_en);
        always_ff @(posedge i_clk or negedge nrst) begin
            if (!nrst) begin
                ctrl_a_r[n] <= glue_logic_pkg::RST_CTRL;
                ctrl_b_r[n] <= glue_logic_pkg::RST_CTRL;
                ctrl_c_r[n] <= glue_logic_pkg::RST_SEQ;
                truth_r[n] <= glue_logic_pkg::RST_CTRL;
            end else if (hit) begin
                unique case (tofs)
                    glue_logic_pkg::OFS_T0_A: begin
                        // [RULE20] table enable always writable
                        ctrl_a_r[n][0] <= new_en;
                        if (prot_ok) begin
                            ctrl_a_r[n][7:3] <= i_avs_writedata[7:3];
                        end
                    end
                    glue_logic_pkg::OFS_T0_B: begin
                        if (prot_ok) begin
                            ctrl_b_r[n] <= i_avs_writedata[7:0];
                        end
                    end
                    glue_logic_pkg::OFS_T0_C: begin
                        if (prot_ok) begin
                            ctrl_c_r[n] <= i_avs_writedata[3:0];
                        end
                    end
                    default: begin
                        // truth bits are never protected
                        truth_r[n] <= i_avs_writedata[7:0];
                    end
                endcase
            end
        end
    end

    // read data, latched in the wait cycle
    logic [31:0] rd_nxt;
    always_comb begin
        rd_nxt = 32'h0000_0000;
        if (i_avs_address == glue_logic_pkg::OFS_GLOBAL) begin
            rd_nxt[0] = global_en_r;
        end else if (i_avs_address == glue_logic_pkg::OFS_SEQ) begin
            rd_nxt[3:0] = seq_sel_r;
        end else if (i_avs_address == glue_logic_pkg::OFS_STATUS) begin
            // live output state
            rd_nxt[2:0] = {o_sequential_output, o_table_event};
        end else if (in_tbl) begin
            unique case (tofs)
                glue_logic_pkg::OFS_T0_A: rd_nxt[7:0] = ctrl_a_r[tsel];
                glue_logic_pkg::OFS_T0_B: rd_nxt[7:0] = ctrl_b_r[tsel];
                glue_logic_pkg::OFS_T0_C: rd_nxt[3:0] = ctrl_c_r[tsel];
                default: rd_nxt[7:0] = truth_r[tsel];
            endcase
        end
    end
    always_ff @(posedge i_clk or negedge nrst) begin
        if (!nrst) begin
            o_avs_readdata <= 32'h0000_0000;
        end else if (i_avs_read && wait_r) begin
            // unmapped addresses read as zero
            o_avs_readdata <= rd_nxt;
        end
    end

    // [RULE21] no debug gating: i_debug_halt is deliberately unused
    // table datapaths
    logic [1:0] lut_out; // direct combinational outputs
    logic [1:0] stage_out; // after filter or edge detector
    logic [1:0] tick; // table clock strike
    logic [1:0] run; // table enabled with block enabled
    for (genvar n = 0; n < 2; n++) begin : g_tbl
        logic [2:0] pins;
        logic [2:0] in;
        logic link;
        logic [3:0] sh_r; // filter shift chain
        logic in2_d_r; // previous input 2, for clock edges
        logic edge_d_r; // edge detector history
        logic [1:0] fsel;
        assign pins = (n == 0) ? i_table0_input_pins : i_table1_input_pins;
        // [RULE5] table 1 feeds table 0 only
        assign link = (n == 0) ? lut_out[1] : 1'b0;
        logic [3:0] sel [3]; // source select per input
        // [RULE3] from second and third control
        assign sel[0] = ctrl_b_r[n][3:0];
        assign sel[1] = ctrl_b_r[n][7:4];
        assign sel[2] = ctrl_c_r[n];
        for (genvar y = 0; y < 3; y++) begin : g_in
            assign in[y] = src_mux(sel[y], seq_r, link, i_event_line_zero,
                                   i_event_line_one, pins[y], i_periph);
        end
        assign run[n] = global_en_r & ctrl_a_r[n][glue_logic_pkg::BIT_ENABLE];
        assign lut_out[n] = run[n] & lut_eval(truth_r[n], in);
        assign fsel = ctrl_a_r[n][5:4];
        // [RULE26] bus clock, or rising edges of input 2
        assign tick[n] = ctrl_a_r[n][glue_logic_pkg::BIT_TABLE_CLOCK_SOURCE] ?
                         (in[2] & ~in2_d_r) : 1'b1;
        always_ff @(posedge i_clk or negedge nrst) begin
            if (!nrst) begin
                in2_d_r <= 1'b0;
            end else begin
                in2_d_r <= in[2];
            end
        end
        // sync taps stage two; filter wants four equal
        always_ff @(posedge i_clk or negedge nrst) begin
            if (!nrst) begin
                sh_r <= 4'h0;
            end else if (!run[n]) begin
                // [RULE9] filter cleared once the table is off
                sh_r <= 4'h0;
            end else if (tick[n]) begin
                // [RULE8] delay line on the table clock
                sh_r <= {sh_r[2:0], lut_out[n]};
            end
        end
        logic filt_r; // filter result with hysteresis
        always_ff @(posedge i_clk or negedge nrst) begin
            if (!nrst) begin
                filt_r <= 1'b0;
            end else if (!run[n]) begin
                filt_r <= 1'b0;
            end else if (tick[n] && sh_r == 4'hf) begin
                filt_r <= 1'b1;
            end else if (tick[n] && sh_r == 4'h0) begin
                filt_r <= 1'b0;
            end
        end
        logic filt_val;
        // [RULE22] pass direct or through the chosen filter
        assign filt_val = (fsel == glue_logic_pkg::FILT_SYNC) ? sh_r[1] :
                          (fsel == glue_logic_pkg::FILT_FILTER) ? filt_r :
                          lut_out[n];
        always_ff @(posedge i_clk or negedge nrst) begin
            if (!nrst) begin
                edge_d_r <= 1'b0;
            end else if (!run[n]) begin
                // [RULE12] edge history cleared after disable
                edge_d_r <= 1'b0;
            end else if (tick[n]) begin
                edge_d_r <= filt_val;
            end
        end
        // [RULE10] rising edge pulse when enabled
        assign stage_out[n] = ctrl_a_r[n][glue_logic_pkg::BIT_EDGE] ?
                              (filt_val & ~edge_d_r & tick[n]) : filt_val;
    end

    // sequential element on the table 0 clock
    logic seq_nxt;
    always_comb begin
        seq_nxt = seq_r;
        // [RULE14] inputs from both table stages
        unique case (seq_sel_r)
            glue_logic_pkg::SEQ_DFF: begin
                // [RULE27] load d when gate high
                if (tick[0] && stage_out[1]) begin
                    seq_nxt = stage_out[0];
                end
            end
            glue_logic_pkg::SEQ_JK: begin
                // [RULE24] hold, clear, set, toggle
                if (tick[0]) begin
                    unique case (stage_out)
                        2'b10: seq_nxt = 1'b0;
                        2'b01: seq_nxt = 1'b1;
                        2'b11: seq_nxt = ~seq_r;
                        default: seq_nxt = seq_r;
                    endcase
                end
            end
            glue_logic_pkg::SEQ_LATCH: begin
                // [RULE28] transparent while gate high
                if (stage_out[1]) begin
                    seq_nxt = stage_out[0];
                end
            end
            glue_logic_pkg::SEQ_RS: begin
                // [RULE25] both high holds
                if (stage_out == 2'b01) begin
                    seq_nxt = 1'b1;
                end else if (stage_out == 2'b10) begin
                    seq_nxt = 1'b0;
                end
            end
            // [RULE23] disable and reserved codes give zero
            default: seq_nxt = 1'b0;
        endcase
    end
    // [RULE13] [RULE15] one element per pair on table 0 clock
    always_ff @(posedge i_clk or negedge nrst) begin
        if (!nrst) begin
            seq_r <= 1'b0;
        end else if (!run[0]) begin
            // [RULE16] cleared while table 0 is off
            seq_r <= 1'b0;
        end else begin
            seq_r <= seq_nxt;
        end
    end

    // registered outputs, pin gated by its enable
    always_ff @(posedge i_clk or negedge nrst) begin
        if (!nrst) begin
            o_table_output_pin <= 2'b00;
            o_table_event <= 2'b00;
            o_sequential_output <= 1'b0;
        end else begin
            o_table_event <= stage_out;
            o_table_output_pin <= stage_out &
                {ctrl_a_r[1][glue_logic_pkg::BIT_OUTEN],
                 ctrl_a_r[0][glue_logic_pkg::BIT_OUTEN]};
            o_sequential_output <= seq_r;
        end
    end
endmodule

// >>> glue_partner.sv
// Purpose: far-side model: pins, event lines, peripherals, debug halt
// Assumes: requested levels change just after a rising edge
// Notes: one register stage, like a pad synchroniser
`timescale 1ns/1ps
module glue_partner (
    input wire logic i_clk,
    input wire logic [9:0] i_req,
    output logic [2:0] o_pins0,
    output logic [2:0] o_pins1,
    output logic o_ev0,
    output logic o_ev1,
    output logic [1:0] o_per,
    output logic o_halt
);
    initial o_halt = 1'b0; // known start for the toggle
    // one stage late, like a pad
    always @(posedge i_clk) begin
        {o_per, o_ev1, o_ev0, o_pins1, o_pins0} <= i_req;
    end
    // debug halt toggles all run
    always @(posedge i_clk) begin
        o_halt <= ~o_halt;
    end
endmodule

// >>> glue_logic_sva.sv
// Purpose: port-level checker for the glue logic block
// Assumes: one clock, enables shadowed from taken bus writes
// Notes: enable bits are never protected, so shadows are exact
`timescale 1ns/1ps
module glue_logic_sva (
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire logic [5:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    input wire logic [3:0] i_avs_byteenable,
    input wire logic [31:0] o_avs_readdata,
    input wire logic o_avs_waitrequest,
    input wire logic [1:0] o_table_output_pin,
    input wire logic [1:0] o_table_event,
    input wire logic o_sequential_output
);
    logic glb_r; // global enable shadow
    logic [1:0] ten_r; // table enable shadows
    logic take; // write accepted at this edge
    assign take = i_avs_write && !o_avs_waitrequest && i_avs_byteenable[0];
    // shadow the enables from accepted writes
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            glb_r <= 1'b0;
            ten_r <= 2'b00;
        end else if (take) begin
            if (i_avs_address == 6'h00) glb_r <= i_avs_writedata[0];
            if (i_avs_address == 6'h14) ten_r[0] <= i_avs_writedata[0];
            if (i_avs_address == 6'h24) ten_r[1] <= i_avs_writedata[0];
        end
    end
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_nrst);
    AST_ANSWER: assert property ((i_avs_read || i_avs_write)
        && o_avs_waitrequest |=> !o_avs_waitrequest)
        else $error("bus request not answered after one wait");
    AST_ONE_WAIT: assert property (!o_avs_waitrequest |=> o_avs_waitrequest)
        else $error("answer stood longer than one cycle");
    AST_UPPER_ZERO: assert property (o_avs_readdata[31:8] == 24'h0)
        else $error("read data above bit 7 not zero");
    AST_UNMAPPED: assert property (i_avs_read && !o_avs_waitrequest
        && (i_avs_address inside {6'h08, 6'h0c, 6'h10, 6'h38, 6'h3c})
        |-> o_avs_readdata == 32'h0)
        else $error("unmapped read not zero");
    AST_PIN_GATED: assert property (
        (o_table_output_pin & ~o_table_event) == 2'b00)
        else $error("pin high while stage output low");
    AST_SEQ_CLEAR: assert property (
        !ten_r[0] [*3] |-> !o_sequential_output)
        else $error("sequential output set while table 0 off");
    AST_T0_OFF: assert property (
        (!glb_r || !ten_r[0]) [*4] |-> !o_table_event[0])
        else $error("table 0 output high while off");
    AST_T1_OFF: assert property (
        (!glb_r || !ten_r[1]) [*5] |-> !o_table_event[1])
        else $error("table 1 output high while off");
    COV_SEQ: cover property (o_sequential_output);
    COV_PULSE: cover property (o_table_event[0] ##1 !o_table_event[0]);
    COV_SEQ_WR: cover property (take && i_avs_address == 6'h04);
endmodule
bind glue_logic glue_logic_sva u_glue_logic_sva (.*);

// >>> testbench.sv
// Purpose: self-checking bench for the glue logic block
// Assumes: slave answers after one wait cycle, partner adds one stage
// Notes: table 0 clocked from input 2 steps the sequential element
`timescale 1ns/1ps
module testbench;
    logic clk = 1'b0; // 200 MHz
    logic nrst = 1'b0; // active low reset
    logic rd = 1'b0; // bus read
    logic wr = 1'b0; // bus write
    logic [5:0] adr = 6'h00;
    logic [31:0] wd = 32'h0;
    logic [31:0] rdat, r; // read data, last answer
    logic wt; // waitrequest
    logic [9:0] req = 10'h000; // far-side levels
    logic [2:0] p0, p1;
    logic e0, e1, hlt, sq;
    logic [1:0] per, tout, tev;
    int n_mismatch = 0;
    int n_checks = 0;
    int cyc = 0;
    glue_partner u_glue_partner (.i_clk(clk), .i_req(req), .o_pins0(p0),
        .o_pins1(p1), .o_ev0(e0), .o_ev1(e1), .o_per(per), .o_halt(hlt));
    glue_logic u_glue_logic (.i_clk(clk), .i_nrst(nrst),
        .i_avs_address(adr), .i_avs_read(rd), .i_avs_write(wr),
        .i_avs_writedata(wd), .i_avs_byteenable(4'h1),
        .o_avs_readdata(rdat), .o_avs_waitrequest(wt),
        .i_table0_input_pins(p0), .i_table1_input_pins(p1),
        .i_event_line_zero(e0), .i_event_line_one(e1), .i_periph(per),
        .i_debug_halt(hlt), .o_table_output_pin(tout),
        .o_table_event(tev), .o_sequential_output(sq));
    always #2.5 clk = ~clk;
    // hang guard
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_mismatch++;
            conclude();
        end
    end
    task automatic conclude();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [7:0] s, e);
        n_checks++;
        if (s !== e) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", nm, e, s);
        end
    endtask
    // one access; leading edge parts release and raise
    task automatic bus(input logic w, input logic [5:0] a, logic [7:0] d);
        @(posedge clk);
        adr <= a;
        wd <= {24'h0, d};
        wr <= w;
        rd <= ~w;
        do @(posedge clk); while (wt !== 1'b0);
        r = rdat;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask
    task automatic rchk(input logic [5:0] a, input logic [7:0] e);
        bus(1'b0, a, 8'h00);
        chk("reg", r[7:0], e);
    endtask
    // disable first so protected fields open
    task automatic cfg(input int n, input logic [7:0] a, b, t, c);
        logic [5:0] o;
        o = n ? 6'h24 : 6'h14;
        bus(1'b1, o, 8'h00);
        bus(1'b1, o + 6'h04, b);
        bus(1'b1, o + 6'h08, c);
        bus(1'b1, o + 6'h0c, t);
        bus(1'b1, o, a);
    endtask
    task automatic cnt(input int n, output int c);
        c = 0;
        repeat (n) begin
            @(posedge clk);
            c += int'(tev[0]);
        end
    endtask
    // model next state: a table 0, b table 1
    function automatic logic nxt(input logic [3:0] m, input logic q, a, b);
        case (m)
            glue_logic_pkg::SEQ_JK: return a ? (b ? ~q : 1'b1) : (b ? 1'b0 : q);
            glue_logic_pkg::SEQ_RS: return (a ^ b) ? a : q;
            default: return b ? a : q;
        endcase
    endfunction
    task automatic t_reset();
        for (int a = 0; a < 64; a += 4) rchk(6'(a), glue_logic_pkg::RST_CTRL);
        $display("reset values done");
    endtask
    task automatic t_truth();
        logic [7:0] t = 8'hb4;
        cfg(0, 8'h09, 8'h55, t, 8'h05);
        for (int i = 0; i < 8; i++) begin
            req <= 10'(i);
            repeat (4) @(posedge clk);
            chk("lut0", 8'(tev[0]), 8'(t[i]));
            chk("pin0", 8'(tout[0]), 8'(t[i]));
        end
        $display("truth table done");
    endtask
    task automatic t_src();
        logic [7:0] ex [2] = '{8'hac, 8'h50};
        logic [9:0] st [2] = '{10'b1001001001, 10'b0110000000};
        for (int k = 0; k < 2; k++) begin
            req <= st[k];
            cfg(1, 8'h01, 8'h00, k ? 8'h00 : 8'hff, 8'h00);
            for (int s = 0; s < 8; s++) begin
                cfg(0, 8'h01, 8'(s), 8'haa, 8'h00);
                repeat (4) @(posedge clk);
                chk("src", 8'(tev[0]), 8'(ex[k][s]));
            end
        end
        $display("sources done");
    endtask
    task automatic t_prot();
        cfg(0, 8'h01, 8'h35, 8'haa, 8'h00);
        bus(1'b1, 6'h18, 8'h77);
        rchk(6'h18, 8'h35);
        bus(1'b1, 6'h04, 8'h02);
        rchk(6'h04, 8'h00);
        bus(1'b1, 6'h14, 8'h20);
        rchk(6'h14, 8'h00);
        bus(1'b1, 6'h14, 8'h21);
        rchk(6'h14, 8'h21);
        $display("protection done");
    endtask
    task automatic t_seq();
        logic q;
        logic [1:0] s [6] = '{2'b10, 2'b00, 2'b11, 2'b01, 2'b11, 2'b00};
        for (int i = 1; i <= 4; i++) begin
            req <= 10'h000;
            bus(1'b1, 6'h14, 8'h00);
            bus(1'b1, 6'h04, 8'(i));
            cfg(1, 8'h01, 8'h05, 8'haa, 8'h00);
            cfg(0, 8'h41, 8'h05, 8'haa, 8'h05);
            q = 1'b0;
            for (int j = 0; j < 6; j++) begin
                req <= {6'h00, s[j][0], 2'b00, s[j][1]};
                repeat (4) @(posedge clk);
                req[2] <= 1'b1;
                repeat (4) @(posedge clk);
                req[2] <= 1'b0;
                repeat (4) @(posedge clk);
                q = nxt(4'(i), q, s[j][1], s[j][0]);
                chk("seq", 8'(sq), 8'(q));
            end
            bus(1'b1, 6'h14, 8'h00);
            repeat (4) @(posedge clk);
            chk("seq off", 8'(sq), 8'h00);
        end
        $display("sequential done");
    endtask
    task automatic t_edge();
        int c;
        req <= 10'h000;
        cfg(0, 8'h91, 8'h05, 8'haa, 8'h00);
        req <= 10'h001;
        cnt(20, c);
        chk("rise", 8'(c), 8'h01);
        req <= 10'h000;
        cnt(20, c);
        chk("fall", 8'(c), 8'h00);
        $display("edge done");
    endtask
    task automatic t_filt();
        int c;
        cfg(0, 8'h21, 8'h05, 8'haa, 8'h00);
        req <= 10'h001;
        @(posedge clk);
        req <= 10'h000;
        cnt(15, c);
        chk("glitch", 8'(c), 8'h00);
        req <= 10'h001;
        repeat (2) @(posedge clk);
        chk("early", 8'(tev[0]), 8'h00);
        repeat (10) @(posedge clk);
        chk("late", 8'(tev[0]), 8'h01);
        $display("filter done");
    endtask
    task automatic t_glob();
        cfg(1, 8'h01, 8'h00, 8'hff, 8'h00);
        repeat (4) @(posedge clk);
        chk("t1 on", 8'(tev[1]), 8'h01);
        bus(1'b1, 6'h00, 8'h00);
        repeat (5) @(posedge clk);
        chk("glb off", 8'(tev), 8'h00);
        bus(1'b1, 6'h00, 8'h01);
        bus(1'b1, 6'h24, 8'h00);
        repeat (5) @(posedge clk);
        chk("t1 off", 8'(tev[1]), 8'h00);
        $display("enables done");
    endtask
    initial begin
        repeat (5) @(posedge clk);
        nrst <= 1'b1;
        repeat (3) @(posedge clk);
        t_reset();
        bus(1'b1, 6'h00, 8'h01);
        t_truth();
        t_src();
        t_prot();
        t_seq();
        t_edge();
        t_filt();
        t_glob();
        conclude();
    end
endmodule
